// ==== dgc_dma_ctrl.v ====
// Decided for this implementation: the placing of the registers and the APB register port.
`include "dgc_defs.vh"

module dgc_dma_ctrl #(
  parameter CNT_W = 16
) (
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        clkEn,
  input  wire        standby,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        nmiPin,
  input  wire        addrErrEvent,
  input  wire [3:0]  externalRequestIn_b,
  output wire        xferValid,
  output reg  [1:0]  xferChan,
  input  wire        xferDone,
  output reg         xferAbort,
  output wire [3:0]  transferEndInterrupt,
  output wire        irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;
  localparam [15:0] OP_RST = `DGC_OP_RESET;

  // ***************************************************************
  // state
  // ***************************************************************
  reg [1:0]           prioMode_q;
  reg                 masterEnable_q;
  reg                 addressErrorFlag_q;
  reg                 nonmaskableEventFlag_q;
  reg                 aeArm_q;
  reg                 nmiArm_q;
  reg [3:0]           channelEnable_q;
  reg [3:0]           transferEndFlag_q;
  reg [3:0]           teArm_q;
  reg [3:0]           endInterruptEnable_q;
  reg [3:0]           autoRequest_q;
  reg [CNT_W-1:0]     transferCount_q [0:3];
  reg [`DGC_IRQ_W-1:0] irqStat_q;
  reg [`DGC_IRQ_W-1:0] irqMask_q;
  reg                 state_q;
  reg                 nmiDly_q;

  wire [3:0]          extReqSync_b;
  wire                nmiSync;
  wire                nmiRise;
  wire [3:0]          eligible;
  wire [3:0]          chanReq;
  wire                grantValid;
  wire [1:0]          grantChan;
  wire                abortCond;
  wire                unitDone;
  wire [3:0]          lastUnit;
  wire [3:0]          teSet;
  wire                wrAcc;
  wire                rdAcc;
  wire                rdSetup;
  wire                addrHit;
  wire                selOp;
  wire                selCh;
  wire                selStat;
  wire                selMask;
  wire                selSts;
  wire [3:0]          selCnt;
  wire [15:0]         opctrlRead;
  wire [15:0]         chctrlRead;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  dgc_sync2 #(
    .WIDTH   (5)
  ) uSync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clkEn   (clkEn),
    .asyncIn ({nmiPin, externalRequestIn_b}),
    .syncOut ({nmiSync, extReqSync_b})
  );

  assign nmiRise = nmiSync & ~nmiDly_q;

  // ***************************************************************
  // APB decode
  // ***************************************************************
  assign selOp   = (paddr == `DGC_OFS_OPCTRL);
  assign selCh   = (paddr == `DGC_OFS_CHCTRL);
  assign selStat = (paddr == `DGC_OFS_IRQSTAT);
  assign selMask = (paddr == `DGC_OFS_IRQMASK);
  assign selSts  = (paddr == `DGC_OFS_STATUS);

  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : gSel
      assign selCnt[c] = (paddr == (`DGC_OFS_CNT0 + 8'h04 * c[7:0]));
    end
  endgenerate

  assign addrHit = selOp | selCh | selStat | selMask | selSts | (|selCnt);
  // prdata is registered in the setup cycle, so access is zero-wait while clkEn is high
  assign pready  = clkEn;
  assign pslverr = psel & penable & ~addrHit;
  assign wrAcc   = psel & penable & pwrite & clkEn & addrHit;
  assign rdAcc   = psel & penable & ~pwrite & clkEn & addrHit;
  assign rdSetup = psel & ~penable & ~pwrite;

  // reserved bits tie to zero
  assign opctrlRead = {6'h00, prioMode_q, 5'h00, addressErrorFlag_q,
                       nonmaskableEventFlag_q, masterEnable_q};

  generate
    for (c = 0; c < 4; c = c + 1) begin : gChRd
      assign chctrlRead[`DGC_CH_STRIDE*c +: `DGC_CH_STRIDE] =
        {autoRequest_q[c], endInterruptEnable_q[c], transferEndFlag_q[c],
         channelEnable_q[c]};
    end
  endgenerate

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (clkEn && rdSetup) begin
      prdata <= 32'h00000000;
      if (selOp) begin
        prdata <= {16'h0000, opctrlRead};
      end else if (selCh) begin
        prdata <= {16'h0000, chctrlRead};
      end else if (selStat) begin
        prdata <= {26'h0000000, irqStat_q};
      end else if (selMask) begin
        prdata <= {26'h0000000, irqMask_q};
      end else if (selSts) begin
        prdata <= {24'h000000, eligible, 1'b0, state_q, xferChan};
      end else if (selCnt[0]) begin
        prdata <= {{(32-CNT_W){1'b0}}, transferCount_q[0]};
      end else if (selCnt[1]) begin
        prdata <= {{(32-CNT_W){1'b0}}, transferCount_q[1]};
      end else if (selCnt[2]) begin
        prdata <= {{(32-CNT_W){1'b0}}, transferCount_q[2]};
      end else if (selCnt[3]) begin
        prdata <= {{(32-CNT_W){1'b0}}, transferCount_q[3]};
      end
    end
  end

  // ***************************************************************
  // operation control register
  // ***************************************************************
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prioMode_q             <= OP_RST[`DGC_OP_PRIO_HI:`DGC_OP_PRIO_LO];
      masterEnable_q         <= 1'b0;
      addressErrorFlag_q     <= 1'b0;
      nonmaskableEventFlag_q <= 1'b0;
      aeArm_q                <= 1'b0;
      nmiArm_q               <= 1'b0;
      nmiDly_q               <= 1'b0;
    end else if (clkEn) begin
      nmiDly_q <= nmiSync;
      if (standby) begin
        prioMode_q             <= 2'h0;
        masterEnable_q         <= 1'b0;
        addressErrorFlag_q     <= 1'b0;
        nonmaskableEventFlag_q <= 1'b0;
        aeArm_q                <= 1'b0;
        nmiArm_q               <= 1'b0;
      end else begin
        if (wrAcc && selOp) begin
          prioMode_q     <= pwdata[`DGC_OP_PRIO_HI:`DGC_OP_PRIO_LO];
          masterEnable_q <= pwdata[`DGC_OP_MASTER];
        end
        // a new event outranks a clear in the same cycle; ones are ignored
        if (addrErrEvent) begin
          addressErrorFlag_q <= 1'b1;
        end else if (wrAcc && selOp && aeArm_q && !pwdata[`DGC_OP_AERR]) begin
          addressErrorFlag_q <= 1'b0;
        end
        if (nmiRise) begin
          nonmaskableEventFlag_q <= 1'b1;
        end else if (wrAcc && selOp && nmiArm_q && !pwdata[`DGC_OP_NMI]) begin
          nonmaskableEventFlag_q <= 1'b0;
        end
        // a clear is honoured only after a read has returned a one
        if (rdAcc && selOp && addressErrorFlag_q) begin
          aeArm_q <= 1'b1;
        end else if ((wrAcc && selOp) || !addressErrorFlag_q) begin
          aeArm_q <= 1'b0;
        end
        if (rdAcc && selOp && nonmaskableEventFlag_q) begin
          nmiArm_q <= 1'b1;
        end else if ((wrAcc && selOp) || !nonmaskableEventFlag_q) begin
          nmiArm_q <= 1'b0;
        end
      end
    end
  end

  // ***************************************************************
  // per-channel control, count and end flag
  // ***************************************************************
  assign unitDone = xferValid & xferDone;

  generate
    for (c = 0; c < 4; c = c + 1) begin : gChan
      // count of zero acts as full range, so a unit ends at one
      assign lastUnit[c] = (transferCount_q[c] == {{(CNT_W-1){1'b0}}, 1'b1});
      assign teSet[c]    = unitDone & (xferChan == c[1:0]) & lastUnit[c];
      // block only while the flags stand; any one of them holds off
      assign eligible[c] = channelEnable_q[c] & masterEnable_q &
                           ~transferEndFlag_q[c] & ~addressErrorFlag_q &
                           ~nonmaskableEventFlag_q;
      assign chanReq[c]  = eligible[c] & (autoRequest_q[c] | ~extReqSync_b[c]);
      assign transferEndInterrupt[c] = transferEndFlag_q[c] & endInterruptEnable_q[c];

      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          channelEnable_q[c]      <= 1'b0;
          transferEndFlag_q[c]    <= 1'b0;
          teArm_q[c]              <= 1'b0;
          endInterruptEnable_q[c] <= 1'b0;
          autoRequest_q[c]        <= 1'b0;
          transferCount_q[c]      <= {CNT_W{1'b0}};
        end else if (clkEn) begin
          if (standby) begin
            channelEnable_q[c]      <= 1'b0;
            transferEndFlag_q[c]    <= 1'b0;
            teArm_q[c]              <= 1'b0;
            endInterruptEnable_q[c] <= 1'b0;
            autoRequest_q[c]        <= 1'b0;
            transferCount_q[c]      <= {CNT_W{1'b0}};
          end else begin
            if (wrAcc && selCh) begin
              channelEnable_q[c]      <= pwdata[`DGC_CH_STRIDE*c + `DGC_CH_EN];
              endInterruptEnable_q[c] <= pwdata[`DGC_CH_STRIDE*c + `DGC_CH_IE];
              autoRequest_q[c]        <= pwdata[`DGC_CH_STRIDE*c + `DGC_CH_AUTO];
            end
            if (teSet[c]) begin
              transferEndFlag_q[c] <= 1'b1;
            end else if (wrAcc && selCh && teArm_q[c] &&
                         !pwdata[`DGC_CH_STRIDE*c + `DGC_CH_TE]) begin
              transferEndFlag_q[c] <= 1'b0;
            end
            if (rdAcc && selCh && transferEndFlag_q[c]) begin
              teArm_q[c] <= 1'b1;
            end else if ((wrAcc && selCh) || !transferEndFlag_q[c]) begin
              teArm_q[c] <= 1'b0;
            end
            if (wrAcc && selCnt[c]) begin
              transferCount_q[c] <= pwdata[CNT_W-1:0];
            end else if (unitDone && xferChan == c[1:0]) begin
              transferCount_q[c] <= transferCount_q[c] - {{(CNT_W-1){1'b0}}, 1'b1};
            end
          end
        end
      end
    end
  endgenerate

  // ***************************************************************
  // arbitration
  // ***************************************************************
  dgc_arbiter uArb (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .clkEn      (clkEn),
    .standby    (standby),
    .prioMode   (prioMode_q),
    .req        (chanReq),
    .svcValid   (unitDone),
    .svcChan    (xferChan),
    .grantValid (grantValid),
    .grantChan  (grantChan)
  );

  // ***************************************************************
  // transfer sequencer: one unit per grant, then rearbitrate
  // ***************************************************************
  assign abortCond = ~masterEnable_q | ~channelEnable_q[xferChan] |
                     addressErrorFlag_q | nonmaskableEventFlag_q;
  // an aborting unit is withdrawn before it can complete
  assign xferValid = (state_q == ST_BUSY) & ~abortCond;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= ST_IDLE;
      xferChan  <= 2'h0;
      xferAbort <= 1'b0;
    end else if (clkEn) begin
      xferAbort <= 1'b0;
      if (standby) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (grantValid) begin
              state_q  <= ST_BUSY;
              xferChan <= grantChan;
            end
          end
          ST_BUSY: begin
            if (abortCond) begin
              state_q   <= ST_IDLE;
              xferAbort <= 1'b1;
            end else if (xferDone) begin
              state_q <= ST_IDLE;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // interrupt status and mask
  // ***************************************************************
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStat_q <= {`DGC_IRQ_W{1'b0}};
      irqMask_q <= {`DGC_IRQ_W{1'b0}};
    end else if (clkEn) begin
      if (standby) begin
        irqStat_q <= {`DGC_IRQ_W{1'b0}};
        irqMask_q <= {`DGC_IRQ_W{1'b0}};
      end else begin
        if (wrAcc && selMask) begin
          irqMask_q <= pwdata[`DGC_IRQ_W-1:0];
        end
        // write one clears; a same-cycle event keeps its bit set
        irqStat_q <= (irqStat_q & ~((wrAcc && selStat) ? pwdata[`DGC_IRQ_W-1:0]
                                                        : {`DGC_IRQ_W{1'b0}}))
                     | {nmiRise, addrErrEvent, teSet};
      end
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

endmodule // dgc_dma_ctrl

// ==== dgc_defs.vh ====
// Overview of operation
// - 16-bit control register, cleared by reset, standby
// - reserved bits read zero, write zero
// - fixed modes: 0,3,2,1 or 1,3,2,0
// - mode 10 round-robin, starts 0,3,2,1
// - mode 11 pin round-robin, starts 3,2,1,0
// - address error flag blocks all channels
// - nonmaskable event flag blocks all channels
// - flags clear by read one, write zero
// - channel runs only with all enable conditions
// - clearing master enable aborts every channel
// - one unit per request, count minus one
// - auto request starts without outside request
// - count zero ends normally, optional interrupt
// - address error or nonmaskable event aborts
// - clearing channel enable aborts that channel
// - pending channels served in priority order
// - end flag only on normal end, blocks
`ifndef DGC_DEFS_VH
`define DGC_DEFS_VH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define DGC_OFS_OPCTRL    8'h00
`define DGC_OFS_CHCTRL    8'h04
`define DGC_OFS_CNT0      8'h08
`define DGC_OFS_IRQSTAT   8'h18
`define DGC_OFS_IRQMASK   8'h1C
`define DGC_OFS_STATUS    8'h20

// ***************************************************************
// operation control fields
// ***************************************************************
`define DGC_OP_MASTER     0
`define DGC_OP_NMI        1
`define DGC_OP_AERR       2
`define DGC_OP_PRIO_LO    8
`define DGC_OP_PRIO_HI    9
`define DGC_OP_RESET      16'h0000

// ***************************************************************
// channel control fields, four bits per channel
// ***************************************************************
`define DGC_CH_EN         0
`define DGC_CH_TE         1
`define DGC_CH_IE         2
`define DGC_CH_AUTO       3
`define DGC_CH_STRIDE     4

// ***************************************************************
// interrupt status bits above the per-channel ones
// ***************************************************************
`define DGC_IRQ_AERR      4
`define DGC_IRQ_NMI       5
`define DGC_IRQ_W         6

// ***************************************************************
// priority modes and arbitration orders (entry 0 in bits 1:0)
// ***************************************************************
`define DGC_PRIO_FIX0     2'h0
`define DGC_PRIO_FIX1     2'h1
`define DGC_PRIO_RR       2'h2
`define DGC_PRIO_PINRR    2'h3
`define DGC_ORDER_FIX0    8'h6C
`define DGC_ORDER_FIX1    8'h2D
`define DGC_ORDER_PINRR   8'h1B

`endif

// ==== dgc_sync2.v ====
// two-stage synchroniser; first stage feeds only the second
module dgc_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             sys_clk,
  input  wire             rst_b,
  input  wire             clkEn,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_q <= {WIDTH{1'b0}};
      stage2_q <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule // dgc_sync2

// ==== dgc_arbiter.v ====
`include "dgc_defs.vh"

module dgc_arbiter (
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire       clkEn,
  input  wire       standby,
  input  wire [1:0] prioMode,
  input  wire [3:0] req,
  input  wire       svcValid,
  input  wire [1:0] svcChan,
  output reg        grantValid,
  output reg  [1:0] grantChan
);

  reg [7:0] rrOrder_q;
  reg [7:0] rrOrder_d;
  reg [1:0] lastMode_q;
  reg [7:0] order;
  reg [2:0] svcPos;
  integer   i;
  integer   j;

  // ***************************************************************
  // effective order and pick
  // ***************************************************************
  always @* begin
    case (prioMode)
      `DGC_PRIO_FIX0: order = `DGC_ORDER_FIX0;
      `DGC_PRIO_FIX1: order = `DGC_ORDER_FIX1;
      default:        order = rrOrder_q;
    endcase
    grantValid = |req;
    grantChan  = 2'h0;
    // walk from lowest to highest so the highest requester wins
    for (i = 3; i >= 0; i = i - 1) begin
      if (req[order[2*i +: 2]]) begin
        grantChan = order[2*i +: 2];
      end
    end
  end

  // ***************************************************************
  // rotation: serviced channel goes to the tail
  // ***************************************************************
  always @* begin
    svcPos = 3'h0;
    for (j = 3; j >= 0; j = j - 1) begin
      if (rrOrder_q[2*j +: 2] == svcChan) begin
        svcPos = j[2:0];
      end
    end
    rrOrder_d = rrOrder_q;
    for (j = 0; j < 3; j = j + 1) begin
      if (j[2:0] >= svcPos) begin
        rrOrder_d[2*j +: 2] = rrOrder_q[2*j+2 +: 2];
      end
    end
    rrOrder_d[7:6] = svcChan;
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rrOrder_q  <= `DGC_ORDER_FIX0;
      lastMode_q <= `DGC_PRIO_FIX0;
    end else if (clkEn) begin
      lastMode_q <= prioMode;
      if (standby) begin
        rrOrder_q  <= `DGC_ORDER_FIX0;
        lastMode_q <= `DGC_PRIO_FIX0;
      end else if (prioMode != lastMode_q) begin
        // entering a rotating mode restarts from its documented order
        rrOrder_q <= (prioMode == `DGC_PRIO_PINRR) ? `DGC_ORDER_PINRR
                                                   : `DGC_ORDER_FIX0;
      end else if (svcValid && prioMode[1]) begin
        rrOrder_q <= rrOrder_d;
      end
    end
  end

endmodule // dgc_arbiter

// ==== dgc_dma_ctrl_asserts.sv ====
module dgc_ctrl_chk #(
  parameter int CNT_W = 16
) (
  input logic        sys_clk,
  input logic        rst_b,
  input logic        clkEn,
  input logic        standby,
  input logic [7:0]  paddr,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        nmiPin,
  input logic        addrErrEvent,
  input logic [3:0]  externalRequestIn_b,
  input logic        xferValid,
  input logic [1:0]  xferChan,
  input logic        xferDone,
  input logic        xferAbort,
  input logic [3:0]  transferEndInterrupt,
  input logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // ***************************************************************
  // control register and aborts
  // ***************************************************************
  resv_read_zero_a: assert property (
    psel && penable && !pwrite && paddr == 8'h00 |-> prdata[31:10] == 22'h0 && prdata[7:3] == 5'h00)
    else $error("reserved control bits read nonzero");
  master_off_a: assert property (
    psel && penable && pwrite && clkEn && paddr == 8'h00 && !pwdata[0] |=> !xferValid)
    else $error("unit still requested after master enable cleared");
  addr_err_block_a: assert property (
    addrErrEvent && clkEn |=> !xferValid [*3])
    else $error("unit requested while address error flag set");
  // sync plus edge detect needs a few edges before the flag lands
  nmi_block_a: assert property (
    $rose(nmiPin) |-> ##5 !xferValid [*2])
    else $error("unit requested after nonmaskable event");
  drop_abort_a: assert property (
    $fell(xferValid) && !$past(xferDone) && !$past(standby) |=> xferAbort)
    else $error("dropped unit without abort pulse");
  abort_pulse_a: assert property (xferAbort |=> !xferAbort)
    else $error("abort pulse longer than one cycle");

  // ***************************************************************
  // unit handshake and end interrupt
  // ***************************************************************
  chan_hold_a: assert property (
    xferValid && !xferDone |=> !xferValid || $stable(xferChan))
    else $error("channel changed during a unit");
  done_gap_a: assert property (xferValid && xferDone |=> !xferValid)
    else $error("no idle cycle after a unit");
  end_irq_cause_a: assert property (
    $rose(|transferEndInterrupt) |-> $past(xferValid && xferDone) || $past(psel && penable && pwrite))
    else $error("end interrupt rose without a finished unit");

  cover property (xferAbort);
  cover property (xferValid && xferDone);
  cover property (irq);
endmodule // dgc_ctrl_chk

bind dgc_dma_ctrl dgc_ctrl_chk #(.CNT_W(CNT_W)) i_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .standby(standby), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .nmiPin(nmiPin), .addrErrEvent(addrErrEvent),
  .externalRequestIn_b(externalRequestIn_b), .xferValid(xferValid), .xferChan(xferChan),
  .xferDone(xferDone), .xferAbort(xferAbort), .transferEndInterrupt(transferEndInterrupt),
  .irq(irq));

// ==== tb_dgc_dma_ctrl.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        standby = 1'b0;
  logic        clkEn = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        nmiPin = 1'b0;
  logic        addrErrEvent = 1'b0;
  logic [3:0]  extReq_b = 4'hF;
  logic        xferDone = 1'b0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         xferValid;
  wire  [1:0]  xferChan;
  wire         xferAbort;
  wire  [3:0]  endIrq;
  wire         irq;
  logic [31:0] rdat;
  logic        rErr;
  int          n_fail = 0;
  int          n_tests = 0;
  logic [1:0]  ord [4][4] = '{'{2'h0, 2'h3, 2'h2, 2'h1}, '{2'h1, 2'h3, 2'h2, 2'h0},
                             '{2'h0, 2'h3, 2'h2, 2'h1}, '{2'h3, 2'h2, 2'h1, 2'h0}};

  always #4 sys_clk = ~sys_clk;

  dgc_dma_ctrl #(.CNT_W(16)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .standby(standby), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nmiPin(nmiPin), .addrErrEvent(addrErrEvent),
    .externalRequestIn_b(extReq_b), .xferValid(xferValid), .xferChan(xferChan),
    .xferDone(xferDone), .xferAbort(xferAbort), .transferEndInterrupt(endIrq), .irq(irq));

  // ***************************************************************
  // bus and compare tasks
  // ***************************************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge sys_clk);
    if (pready !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
    rdat = prdata;
    rErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  // sampled on the falling edge so the grant edge has settled
  task automatic waitv(input logic [1:0] ch);
    int i;
    @(negedge sys_clk);
    for (i = 0; i < 60 && xferValid !== 1'b1; i++) @(negedge sys_clk);
    if (xferValid !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
    chk({30'h0, xferChan}, {30'h0, ch});
  endtask

  task unit(input logic [1:0] ch);
    waitv(ch);
    @(posedge sys_clk);
    xferDone <= 1'b1;
    @(posedge sys_clk);
    xferDone <= 1'b0;
  endtask

  task idle_chk();
    @(negedge sys_clk);
    chk({31'h0, xferValid}, 32'h0);
  endtask

  task print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(8'h00, 32'h0);
    wr(8'h00, 32'h0000FFFF);
    rd(8'h00, 32'h301);
    rd(8'h40, 32'h0);
    chk({31'h0, rErr}, 32'h1);
    for (int m = 0; m < 4; m++) begin
      for (int n = 0; n < 4; n++) wr(8'h08 + 8'(4 * n), 32'h1);
      wr(8'h00, {22'h0, 2'(m), 8'h01});
      wr(8'h04, (m == 0) ? 32'h999D : 32'h9999);
      for (int k = 0; k < 4; k++) unit(ord[m][k]);
      rd(8'h04, (m == 0) ? 32'hBBBF : 32'hBBBB);
      if (m == 0) begin
        chk({28'h0, endIrq}, 32'h1);
        wr(8'h1C, 32'h1);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        wr(8'h1C, 32'h0);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        wr(8'h18, 32'h3F);
        wr(8'h1C, 32'h1);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0);
      end
      wr(8'h04, 32'h0);
      rd(8'h04, 32'h0);
    end
    // mode change into round-robin reloads its start order
    wr(8'h08, 32'h2);
    wr(8'h14, 32'h2);
    wr(8'h00, 32'h201);
    wr(8'h04, 32'h9009);
    for (int k = 0; k < 4; k++) unit(k[0] ? 2'h3 : 2'h0);
    wr(8'h10, 32'h5);
    wr(8'h04, 32'h900);
    waitv(2'h2);
    rd(8'h20, 32'h46);
    wr(8'h04, 32'h0);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, xferAbort}, 32'h1);
    rd(8'h10, 32'h5);
    rd(8'h04, 32'h2002);
    wr(8'h04, 32'h900);
    waitv(2'h2);
    wr(8'h00, 32'h200);
    idle_chk();
    wr(8'h00, 32'h201);
    waitv(2'h2);
    @(posedge sys_clk);
    addrErrEvent <= 1'b1;
    @(posedge sys_clk);
    addrErrEvent <= 1'b0;
    idle_chk();
    rd(8'h00, 32'h205);
    wr(8'h00, 32'h205);
    rd(8'h00, 32'h205);
    wr(8'h00, 32'h201);
    rd(8'h00, 32'h201);
    unit(2'h2);
    rd(8'h10, 32'h4);
    waitv(2'h2);
    @(posedge sys_clk);
    nmiPin <= 1'b1;
    repeat (6) @(negedge sys_clk);
    idle_chk();
    rd(8'h00, 32'h203);
    nmiPin <= 1'b0;
    wr(8'h00, 32'h201);
    rd(8'h00, 32'h201);
    // external request path on channel 1
    wr(8'h0C, 32'h2);
    wr(8'h04, 32'h10);
    idle_chk();
    @(posedge sys_clk);
    extReq_b <= 4'hD;
    for (int k = 0; k < 2; k++) unit(2'h1);
    extReq_b <= 4'hF;
    rd(8'h04, 32'h30);
    @(posedge sys_clk);
    clkEn <= 1'b0;
    standby <= 1'b1;
    @(negedge sys_clk);
    chk({31'h0, pready}, 32'h0);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    standby <= 1'b0;
    rd(8'h00, 32'h201);
    @(posedge sys_clk);
    standby <= 1'b1;
    @(posedge sys_clk);
    standby <= 1'b0;
    rd(8'h00, 32'h0);
    print_verdict();
  end
endmodule // tb
